//--- tpc_pkg.sv
// Shared constants, types and helper functions of the two-channel timer.
package tpc_pkg;

  localparam int TPC_AW = 4;
  localparam int TPC_DW = 8;
  localparam int TPC_CW = 16;

  // Register offsets on the byte-wide register port.
  localparam logic [3:0] TPC_OFF_STATUS_CTRL = 4'h0;
  localparam logic [3:0] TPC_OFF_CNT_HI = 4'h1;
  localparam logic [3:0] TPC_OFF_CNT_LO = 4'h2;
  localparam logic [3:0] TPC_OFF_WRAP_HI = 4'h3;
  localparam logic [3:0] TPC_OFF_WRAP_LO = 4'h4;
  localparam logic [3:0] TPC_OFF_CH0_CTRL = 4'h5;
  localparam logic [3:0] TPC_OFF_CH0_HI = 4'h6;
  localparam logic [3:0] TPC_OFF_CH0_LO = 4'h7;
  localparam logic [3:0] TPC_OFF_CH1_CTRL = 4'h8;
  localparam logic [3:0] TPC_OFF_CH1_HI = 4'h9;
  localparam logic [3:0] TPC_OFF_CH1_LO = 4'hA;

  // Fields of timer_status_control.
  localparam int TPC_SC_OVF_FLAG = 7;
  localparam int TPC_SC_OVF_IE = 6;
  localparam int TPC_SC_HALT = 5;
  localparam int TPC_SC_CLEAR = 4;
  localparam logic [2:0] TPC_PS_EXT = 3'h7;
  localparam logic [2:0] TPC_PS_RST = 3'h0;

  // Fields of each channel_control register.
  localparam int TPC_CH_FLAG = 7;
  localparam int TPC_CH_IE = 6;
  localparam int TPC_CH_BUF = 5;
  localparam int TPC_CH_CMP = 4;
  localparam int TPC_CH_ELS_HI = 3;
  localparam int TPC_CH_ELS_LO = 2;
  localparam int TPC_CH_TOV = 1;
  localparam int TPC_CH_MAX = 0;

  // Output actions of edge_level_select in compare modes.
  localparam logic [1:0] TPC_ELS_NONE = 2'h0;
  localparam logic [1:0] TPC_ELS_TOGGLE = 2'h1;
  localparam logic [1:0] TPC_ELS_CLEAR = 2'h2;
  localparam logic [1:0] TPC_ELS_SET = 2'h3;

  // Reset values.
  localparam logic [15:0] TPC_CNT_RST = 16'h0000;
  localparam logic [15:0] TPC_WRAP_RST = 16'hFFFF;
  localparam logic [15:0] TPC_CMP_RST = 16'h0000;
  localparam logic [6:0] TPC_CH_CTRL_RST = 7'h00;
  localparam logic [5:0] TPC_PRE_RST = 6'h00;

  typedef enum {TPC_CH_PORT, TPC_CH_CAPTURE, TPC_CH_COMPARE, TPC_CH_OFF} tpc_chmode_t;

  // Hardware set wins over a software clear in the same cycle.
  function automatic logic tpc_flag_next(input logic flag, input logic evt, input logic clr);
    return evt ? 1'b1 : (clr ? 1'b0 : flag);
  endfunction

  // Two-step clear arming: armed by a read of a set flag, dropped by any new event.
  function automatic logic tpc_arm_next(input logic arm, input logic evt, input logic clr, input logic rd_set);
    return (evt || clr) ? 1'b0 : (rd_set ? 1'b1 : arm);
  endfunction

  // Divide-by-2^sel tick from the free prescaler count.
  function automatic logic tpc_presc_tick(input logic [5:0] pre, input logic [2:0] sel);
    logic [5:0] mask;
    mask = (6'h01 << sel) - 6'h01;
    return (pre & mask) == mask;
  endfunction

endpackage

//--- tpc_chan_if.sv
// Signals between the timer core and one channel.
`timescale 1ns/1ps
`default_nettype none
interface tpc_chan_if;
  logic run_tick;
  logic ovf_evt;
  logic [15:0] cnt_next;
  logic [15:0] cmp_val;
  logic wr_ctrl;
  logic rd_ctrl;
  logic [7:0] wdata;
  logic clr_ok;
  logic cap_ok;
  logic pin_in;
  logic disabled;
  logic [7:0] ctrl_rd;
  logic pin_out;
  logic pin_oe;
  logic irq;
  modport core (output run_tick, ovf_evt, cnt_next, cmp_val, wr_ctrl, rd_ctrl, wdata, clr_ok, cap_ok,
                pin_in, disabled, input ctrl_rd, pin_out, pin_oe, irq);
  modport chan (input run_tick, ovf_evt, cnt_next, cmp_val, wr_ctrl, rd_ctrl, wdata, clr_ok, cap_ok,
                pin_in, disabled, output ctrl_rd, pin_out, pin_oe, irq);
endinterface
`default_nettype wire

//--- tpc_channel.sv
// One capture/compare channel with PWM output control.
`timescale 1ns/1ps
`default_nettype none
module tpc_channel #(
  parameter bit HAS_BUF = 1'b0
) (
  input wire logic i_sys_clk, // Bus clock.
  input wire logic i_rst_b, // Synchronous reset, active low.
  tpc_chan_if.chan ch // Link to the timer core.
);
  import tpc_pkg::*;

  logic [6:0] ctrl_q;
  logic flag_q;
  logic arm_q;
  logic out_q;
  logic oe_q;
  logic pin_prev_q;
  tpc_chmode_t mode;
  logic buf_mode;
  logic [1:0] els;
  logic cmp_evt;
  logic cap_evt;
  logic evt;
  logic clr;

  assign buf_mode = HAS_BUF && ctrl_q[TPC_CH_BUF];
  assign els = ctrl_q[TPC_CH_ELS_HI:TPC_CH_ELS_LO];

  always_comb begin
    if (ch.disabled) begin
      mode = TPC_CH_OFF;
    end else if (els == TPC_ELS_NONE) begin
      mode = TPC_CH_PORT;
    end else if (!buf_mode && !ctrl_q[TPC_CH_CMP]) begin
      mode = TPC_CH_CAPTURE;
    end else begin
      mode = TPC_CH_COMPARE;
    end
  end

  // Mode 0:1 with no pin action still flags compares for software polling.
  assign cmp_evt = ch.run_tick && (ch.cnt_next == ch.cmp_val) &&
                   (mode == TPC_CH_COMPARE || (mode == TPC_CH_PORT && ctrl_q[TPC_CH_CMP] && !buf_mode));
  assign cap_evt = (mode == TPC_CH_CAPTURE) && ch.cap_ok &&
                   ((els[0] && ch.pin_in && !pin_prev_q) || (els[1] && !ch.pin_in && pin_prev_q));
  assign evt = cmp_evt || cap_evt;
  assign clr = ch.wr_ctrl && !ch.wdata[TPC_CH_FLAG] && arm_q && ch.clr_ok;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ctrl_q <= TPC_CH_CTRL_RST;
    end else if (ch.wr_ctrl) begin
      ctrl_q <= ch.wdata[6:0] & {1'b1, HAS_BUF, 5'h1F};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      flag_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      flag_q <= tpc_flag_next(flag_q, evt, clr);
      arm_q <= tpc_arm_next(arm_q, evt, clr, ch.rd_ctrl && flag_q && ch.clr_ok);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= ch.pin_in;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      out_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      oe_q <= (mode == TPC_CH_COMPARE);
      case (mode)
        TPC_CH_PORT: begin
          out_q <= !ctrl_q[TPC_CH_CMP];
        end
        TPC_CH_COMPARE: begin
          if (ctrl_q[TPC_CH_TOV] && ctrl_q[TPC_CH_MAX]) begin
            out_q <= (els == TPC_ELS_CLEAR);
          end else if (ch.ovf_evt && ch.run_tick && ctrl_q[TPC_CH_TOV]) begin
            out_q <= !out_q;
          end else if (cmp_evt) begin
            case (els)
              TPC_ELS_TOGGLE: out_q <= !out_q;
              TPC_ELS_CLEAR: out_q <= 1'b0;
              TPC_ELS_SET: out_q <= 1'b1;
              default: out_q <= out_q;
            endcase
          end
        end
        default: begin
          out_q <= out_q;
        end
      endcase
    end
  end

  assign ch.ctrl_rd = {flag_q, ctrl_q};
  assign ch.pin_out = out_q;
  assign ch.pin_oe = oe_q;
  assign ch.irq = flag_q && ctrl_q[TPC_CH_IE];

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  AST_CH_FLAG_SET: assert property (evt |=> flag_q) else $error("channel flag not set by event");
  AST_CH_FULL: assert property ((mode == TPC_CH_COMPARE && ctrl_q[TPC_CH_TOV] && ctrl_q[TPC_CH_MAX] && !ch.wr_ctrl)
    |=> out_q == (els == TPC_ELS_CLEAR)) else $error("full duty output wrong");
  AST_CH_NO_TOV: assert property ((mode == TPC_CH_COMPARE && !ctrl_q[TPC_CH_TOV] && !cmp_evt)
    |=> $stable(out_q)) else $error("output moved without compare");
  AST_CH_OFF: assert property (ch.disabled |=> !oe_q) else $error("linked second pin still driven");
endmodule // tpc_channel
`default_nettype wire

//--- tpc_timer.sv
// Two-channel timer top: counter, prescaler, register port and linked PWM pair.
//
// Operation
// - Mode pair 0:1 selects unbuffered, 1:0 buffered compare or PWM.
// - Edge/level 1:0 clears output on compare, 1:1 sets it.
// - Link bit in channel 0 pairs both channels; channel 0 values act first.
// - Toggle-at-wrap clear means no overflow toggle, giving 0% duty.
// - Full-duty with toggle-at-wrap set holds the pin at 100% duty.
// - Overflow flag sets at the wrap value; interrupt only when enabled.
// - Channel flag sets on capture or compare; interrupt when enabled.
// - In wait mode timer runs, registers closed, enabled interrupts wake.
// - In stop mode timer halts, keeps all state, resumes afterwards.
// - During break the counter holds and captures are suppressed.
// - In break flags clear only with break-clear enable; pending clears finish later.
// - Each pin is capture or compare; only channel 0 carries buffered output.
// - Prescale select all ones uses the external clock pin.
// - Overflow flag clears by read-while-set then write 0; new overflow cancels.
// - Overflow enable gates overflow interrupts; reset clears it.
// - Halt freezes the counter, set by reset, and blocks captures.
// - Counter-clear write zeroes counter and prescaler, self-clears, reads 0.
// - Halt and clear written together leave the counter stopped at zero.
// - After reaching wrap, counter restarts from zero on the next tick.
// - Prescale codes 0 to 6 divide by 1 to 64; reset clears them.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer (
  input wire logic i_sys_clk, // Bus clock, 200 MHz.
  input wire logic i_rst_b, // Synchronous reset, active low.
  input wire logic [tpc_pkg::TPC_AW-1:0] i_addr, // Register offset.
  input wire logic [tpc_pkg::TPC_DW-1:0] i_wr_data, // Write data.
  input wire logic i_wr_stb, // One-cycle write strobe.
  input wire logic i_rd_stb, // One-cycle read strobe.
  output logic [tpc_pkg::TPC_DW-1:0] o_rd_data, // Read data, cycle after the strobe.
  input wire logic i_wait_mode, // Processor in wait mode.
  input wire logic i_stop_mode, // Processor in stop mode.
  input wire logic i_break, // Debug break active.
  input wire logic i_break_clear_en, // Break-clear enable from the system.
  input wire logic i_ext_clk, // External timer clock pin.
  input wire logic i_ch0_pin_in, // Channel 0 pin level.
  input wire logic i_ch1_pin_in, // Channel 1 pin level.
  output logic o_ch0_pin_out, // Channel 0 pin drive level.
  output logic o_ch0_pin_oe, // Channel 0 pin driven when high.
  output logic o_ch1_pin_out, // Channel 1 pin drive level.
  output logic o_ch1_pin_oe, // Channel 1 pin driven when high.
  output logic o_irq, // Timer interrupt request, level.
  output logic o_wake // Wake request while in wait mode.
);
  import tpc_pkg::*;

  logic [15:0] cnt_q;
  logic [15:0] wrap_q;
  logic [5:0] pre_q;
  logic [15:0] cmp_q [2];
  logic ovf_flag_q;
  logic ovf_arm_q;
  logic ovf_ie_q;
  logic halt_q;
  logic [2:0] ps_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic last_wr_ch1_q;
  logic active_ch1_q;
  logic [7:0] rd_data_q;
  logic irq_q;
  logic wake_q;
  logic ch0_out_q;
  logic ch0_oe_q;
  logic ch1_out_q;
  logic ch1_oe_q;

  logic wr;
  logic rd;
  logic clr_ok;
  logic run;
  logic ext_rise;
  logic tick;
  logic run_tick;
  logic clr_wr;
  logic [15:0] cnt_nxt;
  logic ovf_evt;
  logic ovf_clr;
  logic linked;

  tpc_chan_if ch0_if ();
  tpc_chan_if ch1_if ();

  // Registers are closed to the processor while it waits.
  assign wr = i_wr_stb && !i_wait_mode;
  assign rd = i_rd_stb && !i_wait_mode;
  assign clr_ok = !i_break || i_break_clear_en;
  assign run = !halt_q && !i_break && !i_stop_mode;

  // The external pin is only sampled, so it must stay below half the bus rate.
  assign ext_rise = ext_s2_q && !ext_s3_q;
  assign tick = (ps_q == TPC_PS_EXT) ? ext_rise : tpc_presc_tick(pre_q, ps_q);
  assign run_tick = run && tick;
  assign clr_wr = wr && (i_addr == TPC_OFF_STATUS_CTRL) && i_wr_data[TPC_SC_CLEAR];
  assign cnt_nxt = (cnt_q == wrap_q) ? TPC_CNT_RST : cnt_q + 16'h0001;
  assign ovf_evt = run_tick && (cnt_nxt == wrap_q);
  assign ovf_clr = wr && (i_addr == TPC_OFF_STATUS_CTRL) && !i_wr_data[TPC_SC_OVF_FLAG] &&
                   ovf_arm_q && clr_ok;
  assign linked = ch0_if.ctrl_rd[TPC_CH_BUF];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_clk;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pre_q <= TPC_PRE_RST;
    end else if (clr_wr) begin
      pre_q <= TPC_PRE_RST;
    end else if (run) begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_q <= TPC_CNT_RST;
    end else if (clr_wr) begin
      cnt_q <= TPC_CNT_RST;
    end else if (run_tick) begin
      cnt_q <= cnt_nxt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ovf_ie_q <= 1'b0;
      halt_q <= 1'b1;
      ps_q <= TPC_PS_RST;
    end else if (wr && i_addr == TPC_OFF_STATUS_CTRL) begin
      ovf_ie_q <= i_wr_data[TPC_SC_OVF_IE];
      halt_q <= i_wr_data[TPC_SC_HALT];
      ps_q <= i_wr_data[2:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ovf_flag_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else begin
      ovf_flag_q <= tpc_flag_next(ovf_flag_q, ovf_evt, ovf_clr);
      ovf_arm_q <= tpc_arm_next(ovf_arm_q, ovf_evt, ovf_clr,
                                rd && i_addr == TPC_OFF_STATUS_CTRL && ovf_flag_q && clr_ok);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wrap_q <= TPC_WRAP_RST;
    end else if (wr && i_addr == TPC_OFF_WRAP_HI) begin
      wrap_q[15:8] <= i_wr_data;
    end else if (wr && i_addr == TPC_OFF_WRAP_LO) begin
      wrap_q[7:0] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cmp_q[0] <= TPC_CMP_RST;
      cmp_q[1] <= TPC_CMP_RST;
    end else if (wr && i_addr == TPC_OFF_CH0_HI) begin
      cmp_q[0][15:8] <= i_wr_data;
    end else if (wr && i_addr == TPC_OFF_CH0_LO) begin
      cmp_q[0][7:0] <= i_wr_data;
    end else if (wr && i_addr == TPC_OFF_CH1_HI) begin
      cmp_q[1][15:8] <= i_wr_data;
    end else if (wr && i_addr == TPC_OFF_CH1_LO) begin
      cmp_q[1][7:0] <= i_wr_data;
    end
  end

  // The pair written last takes over at the next overflow, so a new width
  // written to the idle pair never lands in the middle of a period.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      last_wr_ch1_q <= 1'b0;
    end else if (wr && (i_addr == TPC_OFF_CH1_HI || i_addr == TPC_OFF_CH1_LO)) begin
      last_wr_ch1_q <= 1'b1;
    end else if (wr && (i_addr == TPC_OFF_CH0_HI || i_addr == TPC_OFF_CH0_LO)) begin
      last_wr_ch1_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      active_ch1_q <= 1'b0;
    end else if (!linked) begin
      active_ch1_q <= 1'b0;
    end else if (ovf_evt) begin
      active_ch1_q <= last_wr_ch1_q;
    end
  end

  assign ch0_if.run_tick = run_tick;
  assign ch0_if.ovf_evt = ovf_evt;
  assign ch0_if.cnt_next = cnt_nxt;
  assign ch0_if.cmp_val = (linked && active_ch1_q) ? cmp_q[1] : cmp_q[0];
  assign ch0_if.wr_ctrl = wr && i_addr == TPC_OFF_CH0_CTRL;
  assign ch0_if.rd_ctrl = rd && i_addr == TPC_OFF_CH0_CTRL;
  assign ch0_if.wdata = i_wr_data;
  assign ch0_if.clr_ok = clr_ok;
  assign ch0_if.cap_ok = run;
  assign ch0_if.pin_in = i_ch0_pin_in;
  assign ch0_if.disabled = 1'b0;

  assign ch1_if.run_tick = run_tick;
  assign ch1_if.ovf_evt = ovf_evt;
  assign ch1_if.cnt_next = cnt_nxt;
  assign ch1_if.cmp_val = cmp_q[1];
  assign ch1_if.wr_ctrl = wr && i_addr == TPC_OFF_CH1_CTRL;
  assign ch1_if.rd_ctrl = rd && i_addr == TPC_OFF_CH1_CTRL;
  assign ch1_if.wdata = i_wr_data;
  assign ch1_if.clr_ok = clr_ok;
  assign ch1_if.cap_ok = run;
  assign ch1_if.pin_in = i_ch1_pin_in;
  assign ch1_if.disabled = linked;

  tpc_channel #(.HAS_BUF(1'b1)) u_ch0 (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .ch(ch0_if.chan)
  );

  tpc_channel #(.HAS_BUF(1'b0)) u_ch1 (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .ch(ch1_if.chan)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rd_data_q <= 8'h00;
    end else if (!rd) begin
      rd_data_q <= 8'h00;
    end else if (i_addr == TPC_OFF_STATUS_CTRL) begin
      rd_data_q <= {ovf_flag_q, ovf_ie_q, halt_q, 2'h0, ps_q};
    end else if (i_addr == TPC_OFF_CNT_HI) begin
      rd_data_q <= cnt_q[15:8];
    end else if (i_addr == TPC_OFF_CNT_LO) begin
      rd_data_q <= cnt_q[7:0];
    end else if (i_addr == TPC_OFF_WRAP_HI) begin
      rd_data_q <= wrap_q[15:8];
    end else if (i_addr == TPC_OFF_WRAP_LO) begin
      rd_data_q <= wrap_q[7:0];
    end else if (i_addr == TPC_OFF_CH0_CTRL) begin
      rd_data_q <= ch0_if.ctrl_rd;
    end else if (i_addr == TPC_OFF_CH0_HI) begin
      rd_data_q <= cmp_q[0][15:8];
    end else if (i_addr == TPC_OFF_CH0_LO) begin
      rd_data_q <= cmp_q[0][7:0];
    end else if (i_addr == TPC_OFF_CH1_CTRL) begin
      rd_data_q <= ch1_if.ctrl_rd;
    end else if (i_addr == TPC_OFF_CH1_HI) begin
      rd_data_q <= cmp_q[1][15:8];
    end else if (i_addr == TPC_OFF_CH1_LO) begin
      rd_data_q <= cmp_q[1][7:0];
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ovf_flag_q && ovf_ie_q) || ch0_if.irq || ch1_if.irq;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= irq_q && i_wait_mode;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ch0_out_q <= 1'b1;
      ch0_oe_q <= 1'b0;
      ch1_out_q <= 1'b1;
      ch1_oe_q <= 1'b0;
    end else begin
      ch0_out_q <= ch0_if.pin_out;
      ch0_oe_q <= ch0_if.pin_oe;
      ch1_out_q <= ch1_if.pin_out;
      ch1_oe_q <= ch1_if.pin_oe;
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_irq = irq_q;
  assign o_wake = wake_q;
  assign o_ch0_pin_out = ch0_out_q;
  assign o_ch0_pin_oe = ch0_oe_q;
  assign o_ch1_pin_out = ch1_out_q;
  assign o_ch1_pin_oe = ch1_oe_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  AST_CLEAR_ZERO: assert property (clr_wr |=> cnt_q == 16'h0000) else $error("clear did not zero counter");
  AST_HALT_CLEAR: assert property ((clr_wr && i_wr_data[TPC_SC_HALT]) |=> (halt_q && cnt_q == 16'h0000))
    else $error("halt with clear did not stop at zero");
  AST_HALT_HOLD: assert property ((halt_q && !clr_wr) |=> $stable(cnt_q)) else $error("counter moved while halted");
  AST_BREAK_HOLD: assert property ((i_break && !clr_wr) |=> $stable(cnt_q)) else $error("counter moved in break");
  AST_STOP_HOLD: assert property ((i_stop_mode && !wr) |=> ($stable(cnt_q) && $stable(wrap_q) && $stable(halt_q)))
    else $error("state changed in stop mode");
  AST_WRAP: assert property ((run_tick && cnt_q == wrap_q && !clr_wr) |=> cnt_q == 16'h0000)
    else $error("counter did not restart after wrap");
  AST_INC: assert property ((run_tick && cnt_q != wrap_q && !clr_wr) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("counter did not add one");
  AST_OVF_SET: assert property (ovf_evt |=> ovf_flag_q) else $error("overflow flag not set");
  AST_OVF_NO_ARM: assert property ((ovf_flag_q && wr && i_addr == TPC_OFF_STATUS_CTRL && !ovf_arm_q) |=> ovf_flag_q)
    else $error("overflow flag cleared without read");
  AST_BREAK_KEEP: assert property ((i_break && !i_break_clear_en && ovf_flag_q) |=> ovf_flag_q)
    else $error("flag cleared during protected break");
  AST_IRQ: assert property ((ovf_flag_q && ovf_ie_q) |=> o_irq) else $error("overflow interrupt missing");
  AST_WAKE: assert property ((o_irq && i_wait_mode) |=> o_wake) else $error("no wake from wait");
  AST_EXT: assert property ((ps_q == TPC_PS_EXT && !ext_rise && !clr_wr) |=> $stable(cnt_q))
    else $error("counter ticked without external edge");

  COV_OVF: cover property (ovf_evt);
  COV_OVF_CLEAR: cover property (ovf_flag_q ##1 ovf_clr ##1 !ovf_flag_q);
  COV_LINK_SWAP: cover property (linked && ovf_evt && last_wr_ch1_q ##1 active_ch1_q);
  COV_EXT_TICK: cover property (ps_q == TPC_PS_EXT && run_tick);
endmodule // tpc_timer
`default_nettype wire

//--- tpc_pins_model.sv
// Far-side model: external timer clock source and the two channel pin wires.
`timescale 1ns/1ps
`default_nettype none
module tpc_pins_model (
  input wire logic i_sys_clk, // Bus clock.
  input wire logic i_run, // External clock source enabled.
  input wire logic i_out0, // Channel 0 drive level.
  input wire logic i_oe0, // Channel 0 drive enable.
  input wire logic i_out1, // Channel 1 drive level.
  input wire logic i_oe1, // Channel 1 drive enable.
  output logic o_ext_clk, // External timer clock.
  output logic o_pin0, // Channel 0 wire level.
  output logic o_pin1 // Channel 1 wire level.
);
  logic [1:0] div_q;
  initial div_q = 2'h0;
  // A quarter of the bus rate keeps well clear of the half-rate ceiling of the sampler.
  always @(posedge i_sys_clk) div_q <= i_run ? div_q + 2'h1 : div_q;
  assign o_ext_clk = div_q[1];
  // Undriven pins rest high on their pull-ups.
  assign o_pin0 = i_oe0 ? i_out0 : 1'b1;
  assign o_pin1 = i_oe1 ? i_out1 : 1'b1;
endmodule // tpc_pins_model
`default_nettype wire

//--- tpc_timer_tb.sv
// Self-checking bench of the two-channel timer through its register port.
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_tb;
  import tpc_pkg::*;
  logic i_sys_clk, i_rst_b, i_wr_stb, i_rd_stb, i_wait_mode, i_stop_mode, i_break, i_break_clear_en;
  logic i_ext_clk, i_ch0_pin_in, i_ch1_pin_in, o_ch0_pin_out, o_ch0_pin_oe, o_ch1_pin_out, o_ch1_pin_oe;
  logic o_irq, o_wake, ext_run;
  logic [3:0] i_addr;
  logic [7:0] i_wr_data, o_rd_data, v;
  int num_errors = 0, tests_run = 0, cycles = 0;

  tpc_timer i_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_wait_mode(i_wait_mode),
    .i_stop_mode(i_stop_mode), .i_break(i_break), .i_break_clear_en(i_break_clear_en), .i_ext_clk(i_ext_clk),
    .i_ch0_pin_in(i_ch0_pin_in), .i_ch1_pin_in(i_ch1_pin_in), .o_ch0_pin_out(o_ch0_pin_out),
    .o_ch0_pin_oe(o_ch0_pin_oe), .o_ch1_pin_out(o_ch1_pin_out), .o_ch1_pin_oe(o_ch1_pin_oe),
    .o_irq(o_irq), .o_wake(o_wake));
  tpc_pins_model i_pins (.i_sys_clk(i_sys_clk), .i_run(ext_run), .i_out0(o_ch0_pin_out), .i_oe0(o_ch0_pin_oe),
    .i_out1(o_ch1_pin_out), .i_oe1(o_ch1_pin_oe), .o_ext_clk(i_ext_clk), .o_pin0(i_ch0_pin_in),
    .o_pin1(i_ch1_pin_in));

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // The ceiling sits well above the roughly 1640 cycles the sequence needs.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1 d = o_rd_data;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Counter advance over exactly 128 bus cycles, taken from two unlatched low-byte reads.
  task automatic rate(input logic [7:0] exp);
    logic [7:0] a, b;
    rd(TPC_OFF_CNT_LO, a);
    repeat (126) @(posedge i_sys_clk);
    rd(TPC_OFF_CNT_LO, b);
    chk(b - a, exp);
  endtask

  // Restart channel 0 with a new control value and record which pin levels appear.
  task automatic pwm(input logic [7:0] ctrl, input logic [1:0] exp);
    logic [1:0] seen;
    wr(TPC_OFF_STATUS_CTRL, 8'h30);
    wr(TPC_OFF_CH0_CTRL, ctrl);
    wr(TPC_OFF_STATUS_CTRL, 8'h00);
    repeat (8) @(posedge i_sys_clk);
    seen = 2'h0;
    repeat (8) begin
      @(posedge i_sys_clk);
      seen = seen | (o_ch0_pin_out ? 2'h2 : 2'h1);
    end
    chk({6'h00, seen}, {6'h00, exp});
  endtask

  initial begin
    i_rst_b = 1'b0;
    {i_wr_stb, i_rd_stb, i_wait_mode, i_stop_mode, i_break, i_break_clear_en, ext_run} = 7'h00;
    i_addr = 4'h0;
    i_wr_data = 8'h00;
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rdc(TPC_OFF_STATUS_CTRL, 8'h20);
    rdc(TPC_OFF_WRAP_LO, 8'hFF);
    rdc(TPC_OFF_CH0_CTRL, 8'h00);
    for (int p = 0; p < 7; p++) begin
      wr(TPC_OFF_STATUS_CTRL, {5'h00, p[2:0]});
      rate(8'h80 >> p);
    end
    ext_run <= 1'b1;
    wr(TPC_OFF_STATUS_CTRL, 8'h07);
    rate(8'h20);
    i_break <= 1'b1;
    rate(8'h00);
    i_break <= 1'b0;
    i_stop_mode <= 1'b1;
    rate(8'h00);
    i_stop_mode <= 1'b0;
    wr(TPC_OFF_STATUS_CTRL, 8'h20);
    rate(8'h00);
    wr(TPC_OFF_STATUS_CTRL, 8'h30);
    rdc(TPC_OFF_CNT_LO, 8'h00);
    rdc(TPC_OFF_STATUS_CTRL, 8'h20);
    wr(TPC_OFF_WRAP_HI, 8'h00);
    wr(TPC_OFF_WRAP_LO, 8'h03);
    wr(TPC_OFF_STATUS_CTRL, 8'h40);
    repeat (8) @(posedge i_sys_clk);
    wr(TPC_OFF_STATUS_CTRL, 8'h60);
    rdc(TPC_OFF_STATUS_CTRL, 8'hE0);
    chk({7'h00, o_irq}, 8'h01);
    wr(TPC_OFF_STATUS_CTRL, 8'hE0);
    rdc(TPC_OFF_STATUS_CTRL, 8'hE0);
    wr(TPC_OFF_STATUS_CTRL, 8'h60);
    rdc(TPC_OFF_STATUS_CTRL, 8'h60);
    chk({7'h00, o_irq}, 8'h00);
    wr(TPC_OFF_STATUS_CTRL, 8'h40);
    repeat (8) @(posedge i_sys_clk);
    i_wait_mode <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk({7'h00, o_wake}, 8'h01);
    rdc(TPC_OFF_STATUS_CTRL, 8'h00);
    i_wait_mode <= 1'b0;
    i_break <= 1'b1;
    wr(TPC_OFF_STATUS_CTRL, 8'h60);
    rd(TPC_OFF_STATUS_CTRL, v);
    wr(TPC_OFF_STATUS_CTRL, 8'h60);
    rdc(TPC_OFF_STATUS_CTRL, 8'hE0);
    i_break_clear_en <= 1'b1;
    // The earlier reads ran with clearing protected and did not arm the clear.
    rd(TPC_OFF_STATUS_CTRL, v);
    wr(TPC_OFF_STATUS_CTRL, 8'h60);
    rdc(TPC_OFF_STATUS_CTRL, 8'h60);
    {i_break, i_break_clear_en} <= 2'h0;
    wr(TPC_OFF_CH0_LO, 8'h01);
    pwm(8'h5A, 2'h3);
    chk({7'h00, o_ch0_pin_oe}, 8'h01);
    rdc(TPC_OFF_CH0_CTRL, 8'hDA);
    chk({7'h00, o_irq}, 8'h01);
    pwm(8'h18, 2'h1);
    pwm(8'h1B, 2'h2);
    pwm(8'h1C, 2'h2);
    pwm(8'h2A, 2'h3);
    chk({7'h00, o_ch1_pin_oe}, 8'h00);
    wrap_up();
  end
endmodule // tpc_timer_tb
`default_nettype wire
